// [design/dram_host_pkg.sv]
package dram_host_pkg;

  // geometry of the memory and its multiplexed address
  localparam int ADDR_PINS  = 10;
  localparam int ROW_BITS   = 10;
  localparam int COL_BITS   = 10;
  localparam int DATA_BITS  = 16;
  localparam int LANE_BITS  = 8;
  localparam int PAGE_WORDS = 1024;
  localparam int FIFO_DEPTH = 16;

  // strobe timing, in ns, and derived clock counts at 25 MHz
  localparam int CLK_NS         = 40;
  localparam int T_ROW_SETUP_NS = 30;   // row addr to row strobe fall, setup only
  localparam int T_ROW_ACC_NS   = 60;   // row access time
  localparam int T_COL_ACC_NS   = 30;   // column/address access time
  localparam int T_PRECHG_NS    = 40;   // row strobe high time
  localparam int ROW_CYC   = (T_ROW_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RACC_CYC  = (T_ROW_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CACC_CYC  = (T_COL_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_CYC   = (T_PRECHG_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_BITS  = 4;
  localparam int SYNC_CYC  = 3;   // pin sampler depth added to column access
  localparam int WE_LOW_CYC = 1;  // late write strobe low time, cycles

  // reset values of the pins
  localparam logic STROBE_IDLE = 1'b1;

  // read and write styles chosen by strobe order
  typedef enum logic [1:0] {
    OP_READ        = 2'h0,
    OP_EARLY_WRITE = 2'h1,
    OP_LATE_WRITE  = 2'h2,
    OP_RMW         = 2'h3
  } op_t;

  // one request entering the command fifo
  typedef struct packed {
    op_t                  op;
    logic [1:0]           lane_en;   // bit0 lower lane, bit1 upper lane
    logic [ROW_BITS-1:0]  row;
    logic [COL_BITS-1:0]  col;
    logic [DATA_BITS-1:0] wdata;
  } req_t;

  // strobe pins driven at the memory
  typedef struct packed {
    logic row_strobe_n;
    logic low_byte_col_strobe_n;
    logic high_byte_col_strobe_n;
    logic write_strobe_n;
    logic out_gate_n;
  } strobes_t;

  localparam int REQ_BITS = $bits(req_t);

endpackage : dram_host_pkg

// [design/req_fifo.sv]
`timescale 1ns/1ns
// synchronous fifo with valid/ready on both sides
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,        // clock
  input  wire logic             reset_in,      // async reset, high
  input  wire logic             wr_valid_in,   // write side valid
  output logic                  wr_ready_out,  // not full, registered
  input  wire logic [WIDTH-1:0] wr_data_in,    // write data
  output logic                  rd_valid_out,  // not empty
  input  wire logic             rd_ready_in,   // read side accepts
  output logic      [WIDTH-1:0] rd_data_out    // head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;
  logic             not_full;
  logic             next_not_full;

  // full flag registered so ready leaves straight from a flop
  assign wr_ready_out = not_full;
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];
  assign push         = wr_valid_in & not_full;
  assign pop          = rd_valid_out & rd_ready_in;

  // next pointer values
  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
    next_not_full = (next_count != (AW+1)'(DEPTH));
  end

  // pointer registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      not_full <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      not_full <= next_not_full;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end
endmodule : req_fifo

// [design/dram_page_host.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Function
// R01: write strobe low writes, high reads
// R02: device ignores data pins while reading
// R03: three write styles chosen by strobe order
// R04: data latched by later falling strobe
// R05: early write: per-lane column strobes latch
// R06: late write: write strobe latches data
// R07: device outputs float until column strobe low
// R08: read data keeps written polarity
// R09: data valid row access after row fall
// R10: late column: valid per-lane column access
// R11: data valid address access after column
// R12: late output gate: valid after gate access
// R13: outputs float on four release events
// R14: read data held until release or recolumn
// R15: early write keeps device outputs floating
// R16: hold row strobe low across page
// R17: any of 1024 columns in open row
// R18: page accesses any order, mixed kinds
// R19: page data holds while column strobe high
// R20: decode column strobes per selected device
// R21: ten-bit row then column on ten pins
// R22: flow-through address latches in device
// R23: release data bus while reading
module dram_page_host (
  input  wire logic                                 sys_clk_in,     // 25 MHz clock
  input  wire logic                                 reset_in,       // async reset, high
  input  wire logic                                 req_valid_in,   // request offered
  output logic                                      req_ready_out,  // fifo has room
  input  wire dram_host_pkg::req_t                  req_in,         // request fields
  output logic                                      rsp_valid_out,  // read data pulse
  output logic      [dram_host_pkg::DATA_BITS-1:0]  rsp_data_out,   // read data
  output logic                                      busy_out,       // cycle in progress
  output logic      [dram_host_pkg::ADDR_PINS-1:0]  addr_out,       // multiplexed address
  output dram_host_pkg::strobes_t                   strobes_out,    // active-low strobes
  input  wire logic [dram_host_pkg::DATA_BITS-1:0]  dq_in,          // data pins in
  output logic      [dram_host_pkg::DATA_BITS-1:0]  dq_out,         // data pins out
  output logic      [1:0]                           dq_oe_out       // per-lane drive enable
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ROW   = 4'h1,
    ST_RAS   = 4'h3,
    ST_COL   = 4'h2,
    ST_CAS   = 4'h6,
    ST_WAIT  = 4'h7,
    ST_WLATE = 4'h5,
    ST_END   = 4'h4,
    ST_PRE   = 4'hC
  } state_t;

  ////////////////////////////////////////////////////////////////////////////////
  logic                                 fifo_valid;
  logic                                 fifo_pop;
  dram_host_pkg::req_t                  head;
  logic [dram_host_pkg::REQ_BITS-1:0]   head_bits;
  state_t                               state, next_state;
  dram_host_pkg::req_t                  cur, next_cur;
  logic                                 row_open, next_row_open;
  logic [dram_host_pkg::CNT_BITS-1:0]   cnt, next_cnt;
  logic [dram_host_pkg::ADDR_PINS-1:0]  next_addr;
  dram_host_pkg::strobes_t              next_strobes;
  logic [dram_host_pkg::DATA_BITS-1:0]  next_dq;
  logic [1:0]                           next_oe;
  logic                                 next_rsp_valid;
  logic [dram_host_pkg::DATA_BITS-1:0]  next_rsp_data;
  logic [dram_host_pkg::DATA_BITS-1:0]  dq_s1, dq_s2, dq_s3;
  logic                                 is_read_phase;
  logic [dram_host_pkg::DATA_BITS-1:0]  dq_agreed;
  logic                                 next_busy;

  // requests queue ahead of the strobe engine
  req_fifo #(
    .WIDTH (dram_host_pkg::REQ_BITS),
    .DEPTH (dram_host_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in    (sys_clk_in),
    .reset_in  (reset_in),
    .wr_valid_in  (req_valid_in),
    .wr_ready_out (req_ready_out),
    .wr_data_in   (req_in),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (head_bits)
  );
  assign head     = dram_host_pkg::req_t'(head_bits);
  assign fifo_pop = fifo_valid && (state == ST_IDLE || state == ST_END)
                    && (!row_open || head.row == cur.row);  // [R16]

  ////////////////////////////////////////////////////////////////////////////////
  // three-stage pin sampler, a value counts once stages two and three agree
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
      dq_agreed <= '0;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      if (dq_s2 == dq_s3) begin
        dq_agreed <= dq_s3;
      end
    end
  end

  assign is_read_phase = (cur.op == dram_host_pkg::OP_READ) || (cur.op == dram_host_pkg::OP_RMW);

  ////////////////////////////////////////////////////////////////////////////////
  // strobe sequencer next state
  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_row_open  = row_open;
    next_cnt       = (cnt != '0) ? dram_host_pkg::CNT_BITS'(cnt - 1'b1) : cnt;
    next_addr      = addr_out;
    next_strobes   = strobes_out;
    next_dq        = dq_out;
    next_oe        = dq_oe_out;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data_out;
    case (state)
      ST_IDLE, ST_END: begin
        if (fifo_pop) begin
          next_cur = head;
          // early write drives data before the column strobes
          next_dq  = head.wdata;
          next_oe  = (head.op == dram_host_pkg::OP_EARLY_WRITE) ? head.lane_en : 2'h0;  // [R23]
          next_strobes.out_gate_n = 1'b1;
          next_strobes.write_strobe_n = (head.op != dram_host_pkg::OP_EARLY_WRITE);  // [R01] [R03]
          if (row_open) begin
            next_addr  = head.col;  // [R17] [R18]
            next_state = ST_COL;
          end else begin
            next_addr  = head.row;  // [R21]
            next_cnt   = dram_host_pkg::CNT_BITS'(dram_host_pkg::ROW_CYC);
            next_state = ST_ROW;
          end
        end else if (row_open) begin
          // close the page when no same-row work waits
          next_strobes.row_strobe_n = 1'b1;
          next_strobes.out_gate_n   = 1'b1;
          next_strobes.write_strobe_n = 1'b1;
          next_oe       = 2'h0;
          next_row_open = 1'b0;
          next_cnt      = dram_host_pkg::CNT_BITS'(dram_host_pkg::PRE_CYC);
          next_state    = ST_PRE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ROW: begin
        if (cnt == '0) begin
          next_strobes.row_strobe_n = 1'b0;  // [R21]
          next_row_open = 1'b1;
          next_cnt      = dram_host_pkg::CNT_BITS'(dram_host_pkg::RACC_CYC);
          next_state    = ST_RAS;
        end
      end
      ST_RAS: begin
        next_addr  = cur.col;  // [R21] [R22]
        next_state = ST_COL;
      end
      ST_COL: begin
        // decoded per lane so unselected lanes stay idle
        next_strobes.low_byte_col_strobe_n  = ~cur.lane_en[0];  // [R05] [R20]
        next_strobes.high_byte_col_strobe_n = ~cur.lane_en[1];  // [R05] [R20]
        next_strobes.out_gate_n = ~is_read_phase;
        next_cnt   = dram_host_pkg::CNT_BITS'(dram_host_pkg::CACC_CYC + dram_host_pkg::SYNC_CYC);
        next_state = ST_CAS;
      end
      ST_CAS: begin
        if (cnt == '0) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (is_read_phase) begin
          // sampled after column access plus sampler delay
          next_rsp_valid = 1'b1;
          next_rsp_data  = dq_agreed;  // [R08] [R09] [R10] [R11] [R12]
        end
        if (cur.op == dram_host_pkg::OP_LATE_WRITE || cur.op == dram_host_pkg::OP_RMW) begin
          next_strobes.out_gate_n = 1'b1;  // [R13]
          next_oe    = cur.lane_en;
          next_dq    = cur.wdata;
          next_cnt   = dram_host_pkg::CNT_BITS'(dram_host_pkg::WE_LOW_CYC);
          next_state = ST_WLATE;
        end else begin
          next_strobes.low_byte_col_strobe_n  = 1'b1;
          next_strobes.high_byte_col_strobe_n = 1'b1;
          next_strobes.write_strobe_n = 1'b1;
          next_oe    = 2'h0;
          next_state = ST_END;
        end
      end
      ST_WLATE: begin
        // write strobe falls after the column strobes, latching data
        if (cnt == '0) begin
          next_state = ST_END;
          next_strobes.low_byte_col_strobe_n  = 1'b1;
          next_strobes.high_byte_col_strobe_n = 1'b1;
          next_strobes.write_strobe_n = 1'b1;
          next_oe = 2'h0;
        end else begin
          next_strobes.write_strobe_n = 1'b0;  // [R04] [R06]
        end
      end
      ST_PRE: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  // sequencer registers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state         <= ST_IDLE;
      cur           <= '0;
      row_open      <= 1'b0;
      cnt           <= '0;
      addr_out      <= '0;
      strobes_out   <= '1;
      dq_out        <= '0;
      dq_oe_out     <= 2'h0;
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= '0;
      busy_out      <= 1'b0;
    end else begin
      state         <= next_state;
      cur           <= next_cur;
      row_open      <= next_row_open;
      cnt           <= next_cnt;
      addr_out      <= next_addr;
      strobes_out   <= next_strobes;
      dq_out        <= next_dq;
      dq_oe_out     <= next_oe;
      rsp_valid_out <= next_rsp_valid;
      rsp_data_out  <= next_rsp_data;
      busy_out      <= next_busy;
    end
  end
endmodule : dram_page_host

// [verification/dram_page_host_properties.sv]
`timescale 1ns/1ns
// strobe ordering and bus ownership seen at the host pins
module dram_page_host_properties (
  input  wire logic                    sys_clk_in,   // 25 MHz clock
  input  wire logic                    reset_in,     // async reset, high
  input  wire logic [9:0]              addr_out,     // multiplexed address
  input  wire dram_host_pkg::strobes_t strobes_out,  // active-low strobes
  input  wire logic [1:0]              dq_oe_out     // per-lane drive enable
);
  wire logic row_n = strobes_out.row_strobe_n;
  wire logic lo_n  = strobes_out.low_byte_col_strobe_n;
  wire logic hi_n  = strobes_out.high_byte_col_strobe_n;
  wire logic we_n  = strobes_out.write_strobe_n;
  wire logic og_n  = strobes_out.out_gate_n;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////
  // row before column, address steady at each latch edge
  a_low_col_row: assert property ($fell(lo_n) |-> !row_n)
    else $error("lower column strobe fell with row closed");
  a_high_col_row: assert property ($fell(hi_n) |-> !row_n)
    else $error("upper column strobe fell with row closed");
  a_row_addr_held: assert property ($fell(row_n) |-> $stable(addr_out))
    else $error("address moved at row strobe fall");
  a_col_addr_held: assert property (($fell(lo_n) || $fell(hi_n)) |-> $stable(addr_out))
    else $error("address moved at column strobe fall");

  ////////////////////////////////////////////////////////////
  // write styles and data bus ownership
  a_early_we_first: assert property (($fell(lo_n) || $fell(hi_n)) && !we_n |-> !$past(we_n))
    else $error("early write strobe not low before column strobe");
  a_early_drives: assert property ($fell(we_n) && lo_n && hi_n |-> dq_oe_out != 2'h0)
    else $error("early write without data driven");
  a_late_gate_off: assert property ($fell(we_n) && !(lo_n && hi_n) |-> og_n && dq_oe_out != 2'h0)
    else $error("late write with gate low or data not driven");
  a_late_pulse: assert property ($fell(we_n) && !(lo_n && hi_n) |=> $rose(we_n))
    else $error("late write strobe not one cycle");
  a_read_released: assert property (!og_n |-> dq_oe_out == 2'h0)
    else $error("host drives data while output gate low");
endmodule : dram_page_host_properties

bind dram_page_host dram_page_host_properties chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .addr_out(addr_out), .strobes_out(strobes_out), .dq_oe_out(dq_oe_out));

// [verification/dram_model.sv]
`timescale 1ns/1ns
// behavioural page-mode memory on the far side of the pins
module dram_model (
  input  wire logic [9:0]              addr_in,     // multiplexed address
  input  wire dram_host_pkg::strobes_t strobes_in,  // active-low strobes
  input  wire logic [15:0]             dq_wire_in,  // resolved data wire
  output logic      [15:0]             dq_drv_out   // memory side of the wire
);
  logic [15:0] mem [int];
  logic [9:0]  row;
  logic [9:0]  col;
  logic [15:0] rd = 16'h5A3C;
  logic [1:0]  vld = 2'h0;
  int          acc_ns = 30;
  wire logic   row_n = strobes_in.row_strobe_n;
  wire logic   lo_n  = strobes_in.low_byte_col_strobe_n;
  wire logic   hi_n  = strobes_in.high_byte_col_strobe_n;

  // merge one byte lane into the stored word
  task automatic put(input int ln);
    logic [15:0] w;
    w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
    w[ln*8 +: 8] = dq_wire_in[ln*8 +: 8];
    mem[{row, col}] = w;
  endtask : put

  // column edge: early write latches its lane, read fetches it
  task automatic lane_edge(input int ln);
    col = addr_in;
    if (!strobes_in.write_strobe_n) begin
      #1 put(ln);
    end else begin
      vld[ln] = 1'b0;
      #(acc_ns) rd[ln*8 +: 8] = mem.exists({row, col}) ? mem[{row, col}][ln*8 +: 8] : 8'h00;
      vld[ln] = 1'b1;
    end
  endtask : lane_edge

  // row then column through the same pins
  always @(negedge row_n) row = addr_in;
  always @(negedge lo_n) lane_edge(0);
  always @(negedge hi_n) lane_edge(1);

  // late write: the write strobe latches lanes whose column strobe is low
  always @(negedge strobes_in.write_strobe_n) begin
    vld = 2'h0;
    #1;
    if (!lo_n) put(0);
    if (!hi_n) put(1);
  end

  // outputs float when the gate rises or the row and both column strobes are up
  always @(posedge strobes_in.out_gate_n) vld = 2'h0;
  always @(posedge row_n or posedge lo_n or posedge hi_n) if (row_n && lo_n && hi_n) vld = 2'h0;

  // released lanes show the inverse of the last value, not a held copy
  assign dq_drv_out[7:0]  = (vld[0] && !strobes_in.out_gate_n) ? rd[7:0] : ~rd[7:0];
  assign dq_drv_out[15:8] = (vld[1] && !strobes_in.out_gate_n) ? rd[15:8] : ~rd[15:8];
endmodule : dram_model

// [verification/dram_page_host_bench.sv]
`timescale 1ns/1ns
module dram_page_host_bench;
  logic                    sys_clk_in, reset_in, req_valid_in, req_ready_out, rsp_valid_out, busy_out;
  dram_host_pkg::req_t     req_in;
  logic [15:0]             rsp_data_out, dq_in, dq_out, mem_drv;
  logic [9:0]              addr_out;
  dram_host_pkg::strobes_t strobes_out;
  logic [1:0]              dq_oe_out;
  logic [15:0]             rsp_q[$];
  int                      n_fail, checks_done, row_falls, stalls;

  ////////////////////////////////////////////////////////////
  // clock, wire resolution and observers
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  assign dq_in = {dq_oe_out[1] ? dq_out[15:8] : mem_drv[15:8], dq_oe_out[0] ? dq_out[7:0] : mem_drv[7:0]};
  always @(negedge strobes_out.row_strobe_n) row_falls++;
  always @(posedge sys_clk_in) if (rsp_valid_out === 1'b1) rsp_q.push_back(rsp_data_out);

  dram_page_host dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_in(req_in), .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .busy_out(busy_out), .addr_out(addr_out), .strobes_out(strobes_out), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out));
  dram_model far_mem (.addr_in(addr_out), .strobes_in(strobes_out), .dq_wire_in(dq_in), .dq_drv_out(mem_drv));

  ////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic send(input dram_host_pkg::op_t op, input logic [1:0] ln, input logic [9:0] row,
                      input logic [9:0] col, input logic [15:0] wd);
    req_in <= '{op, ln, row, col, wd};
    req_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    while (req_ready_out !== 1'b1) begin
      stalls++;
      @(posedge sys_clk_in);
    end
  endtask : send

  task automatic expect_rsp(input logic [15:0] exp);
    int k;
    req_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    k = 0;
    while (rsp_q.size() == 0 && k < 400) begin
      @(posedge sys_clk_in);
      k++;
    end
    check("response present", rsp_q.size() != 0, 1'b1);
    if (rsp_q.size() != 0) check("read data", rsp_q.pop_front(), exp);
  endtask : expect_rsp

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_early();
    send(dram_host_pkg::OP_EARLY_WRITE, 2'h3, 10'h003, 10'h005, 16'hA5C3);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h003, 10'h005, 16'hFFFF);
    expect_rsp(16'hA5C3);
  endtask : t_early

  task automatic t_lanes();
    send(dram_host_pkg::OP_EARLY_WRITE, 2'h1, 10'h003, 10'h005, 16'h1234);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h003, 10'h005, 16'h0000);
    expect_rsp(16'hA534);
    send(dram_host_pkg::OP_EARLY_WRITE, 2'h2, 10'h003, 10'h005, 16'h9900);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h003, 10'h005, 16'h0000);
    expect_rsp(16'h9934);
  endtask : t_lanes

  task automatic t_late();
    send(dram_host_pkg::OP_LATE_WRITE, 2'h3, 10'h007, 10'h3FF, 16'hBEEF);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h007, 10'h3FF, 16'h0000);
    expect_rsp(16'hBEEF);
    send(dram_host_pkg::OP_RMW, 2'h3, 10'h007, 10'h3FF, 16'h0F0F);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h007, 10'h3FF, 16'h0000);
    expect_rsp(16'hBEEF);
    expect_rsp(16'h0F0F);
  endtask : t_late

  task automatic t_page();
    int f0;
    f0 = row_falls;
    send(dram_host_pkg::OP_EARLY_WRITE, 2'h3, 10'h009, 10'h00A, 16'h1111);
    send(dram_host_pkg::OP_LATE_WRITE, 2'h3, 10'h009, 10'h002, 16'h2222);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h009, 10'h00A, 16'h0000);
    send(dram_host_pkg::OP_READ, 2'h3, 10'h009, 10'h002, 16'h0000);
    expect_rsp(16'h1111);
    expect_rsp(16'h2222);
    check("row opens in page", row_falls - f0, 1);
  endtask : t_page

  task automatic t_fifo();
    far_mem.acc_ns = 60;
    stalls = 0;
    for (int i = 0; i < 20; i++) begin
      send(dram_host_pkg::OP_READ, 2'h3, i[0] ? 10'h009 : 10'h003, i[0] ? 10'h00A : 10'h005, 16'h0000);
    end
    check("fifo refused when full", stalls > 0, 1'b1);
    for (int i = 0; i < 20; i++) begin
      expect_rsp(i[0] ? 16'h1111 : 16'h9934);
    end
    check("fifo drained", rsp_q.size(), 0);
    repeat (8) @(posedge sys_clk_in);
    check("busy after drain", busy_out, 1'b0);
    check("row closed after drain", strobes_out.row_strobe_n, 1'b1);
  endtask : t_fifo

  ////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    t_early();
    t_lanes();
    t_late();
    t_page();
    t_fifo();
    final_report();
  end

  initial begin
    #(40 * 5000);
    n_fail++;
    final_report();
  end
endmodule : dram_page_host_bench
